// ### bench/ppb_pin_partner.sv
module ppb_pin_partner (
   input  wire ppb_pkg::ppb_pins_t b_i,
   input  wire ppb_pkg::ppb_pins_t c_i,
   input  wire ppb_pkg::ppb_pins_t d_i,
   input  wire logic [23:0]        ext_i,
   output logic      [7:0]         portb_pins_o,
   output logic      [7:0]         port_c_value_pins_o,
   output logic      [7:0]         port_d_value_pins_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Undriven pins take the far side's own level, never the chip's last value.
   assign portb_pins_o = (b_i.oe & b_i.o) | (~b_i.oe & ext_i[7:0]);
   assign port_c_value_pins_o = (c_i.oe & c_i.o) | (~c_i.oe & ext_i[15:8]);
   assign port_d_value_pins_o = (d_i.oe & d_i.o) | (~d_i.oe & ext_i[23:16]);
endmodule : ppb_pin_partner

// ### bench/ppb_top_asserts.sv
module ppb_top_asserts (
   input wire logic                 clk_i,
   input wire logic                 rst_i,
   input wire ppb_pkg::ppb_bus_t    bus_i,
   input wire ppb_pkg::ppb_periph_t periph_i,
   input wire logic                 oc_owns_pin3_i,
   input wire logic                 oc_pin3_level_i,
   input wire logic [7:0]           port_c_value_pins_i,
   input wire ppb_pkg::ppb_pins_t   portb_o,
   input wire ppb_pkg::ppb_pins_t   port_c_value_o,
   input wire ppb_pkg::ppb_pins_t   port_d_value_o,
   input wire logic [7:0]           port_c_value_data_o,
   input wire logic                 porta_pin3_o,
   input wire logic                 porta_pin3_oe_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_portb_high_addr:
   assert property (bus_i.expanded |=> portb_o.oe == 8'hFF && portb_o.o == $past(bus_i.addr[15:8]))
      else $error("port B lost the high address byte");
   a_port_c_value_bus_dir:
   assert property (bus_i.expanded |=>
      port_c_value_o.oe == {8{$past(bus_i.addr_phase) | !$past(bus_i.rd_nwr)}})
      else $error("port C enable ignores the bus phase");
   a_port_d_value_bus_ctl:
   assert property (bus_i.expanded |=> port_d_value_o.oe[7:6] == 2'b11 &&
      port_d_value_o.o[7:6] == {$past(bus_i.rd_nwr), $past(bus_i.strobe)})
      else $error("port D bits 7 and 6 are not strobe and direction");
   a_spi_in_force:
   assert property (periph_i.spi_en |=> (port_d_value_o.oe[4:2] & ~$past(periph_i.spi_drives)) == 3'h0)
      else $error("an SPI input pin is driven");
   a_spi_slave_sel:
   assert property (periph_i.spi_en && !periph_i.spi_master |=> !port_d_value_o.oe[5])
      else $error("slave select pin driven in slave mode");
   a_uart_rx_in:
   assert property (periph_i.uart_rx_en |=> !port_d_value_o.oe[0])
      else $error("receive pin driven while receiver owns it");
   a_pin3_compare:
   assert property (oc_owns_pin3_i |=> porta_pin3_oe_o && porta_pin3_o == $past(oc_pin3_level_i))
      else $error("output compare does not own pin 3");
   a_port_c_value_copy:
   assert property (!$past(rst_i) |-> port_c_value_data_o == $past(port_c_value_pins_i))
      else $error("port C data does not follow the pins");
endmodule : ppb_top_asserts
bind ppb_top ppb_top_asserts u_chk (.clk_i, .rst_i, .bus_i, .periph_i, .oc_owns_pin3_i,
   .oc_pin3_level_i, .port_c_value_pins_i, .portb_o, .port_c_value_o, .port_d_value_o, .port_c_value_data_o,
   .porta_pin3_o, .porta_pin3_oe_o);

// ### bench/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                 clk_i, rst_i, hsel_i, hwrite_i, oc_owns_pin3_i, oc_pin3_level_i;
   logic                 hreadyout_o, hresp_o, porta_pin3_o, porta_pin3_oe_o;
   logic                 porta_bit7_dir_o, capture_compare_select_o;
   logic [1:0]           htrans_i;
   logic [2:0]           hsize_i;
   logic [31:0]          haddr_i, hwdata_i, hrdata_o, rd, r;
   logic [7:0]           portb_pins_i, port_c_value_pins_i, port_d_value_pins_i, port_c_value_data_o, d, v, p;
   logic [5:0]           port_d_value_to_periph_o;
   logic [23:0]          ext;
   logic [7:0]           mdl [256];
   logic [7:0]           tbl [8] = '{ppb_pkg::IDX_PIO_CTRL, ppb_pkg::IDX_PB_DIR,
      ppb_pkg::IDX_PD_DIR, ppb_pkg::IDX_PC_DIR, ppb_pkg::IDX_PA_CTRL, ppb_pkg::IDX_PB_VAL,
      ppb_pkg::IDX_PC_VAL, ppb_pkg::IDX_PD_VAL};
   ppb_pkg::ppb_bus_t    bus_i;
   ppb_pkg::ppb_periph_t periph_i;
   ppb_pkg::ppb_pins_t   portb_o, port_c_value_o, port_d_value_o;
   int                   error_cnt = 0, comparisons = 0, cycles = 0, seed = 52927;
   ppb_top dut (.clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
      .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .bus_i, .periph_i,
      .oc_owns_pin3_i, .oc_pin3_level_i, .portb_pins_i, .port_c_value_pins_i, .port_d_value_pins_i,
      .portb_o, .port_c_value_o, .port_d_value_o, .port_c_value_data_o, .port_d_value_to_periph_o, .porta_pin3_o,
      .porta_pin3_oe_o, .porta_bit7_dir_o, .capture_compare_select_o);
   ppb_pin_partner u_far (.b_i(portb_o), .c_i(port_c_value_o), .d_i(port_d_value_o), .ext_i(ext),
      .portb_pins_o(portb_pins_i), .port_c_value_pins_o(port_c_value_pins_i), .port_d_value_pins_o(port_d_value_pins_i));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         error_cnt++;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // One transfer; the model only learns a write once its data phase is accepted.
   task automatic ahb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      @(posedge clk_i);
      hsel_i   <= 1'b1;
      htrans_i <= ppb_pkg::HTRANS_NONSEQ;
      haddr_i  <= {22'h0, idx, 2'h0};
      hwrite_i <= wr;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      hsel_i   <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= wd;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      rd = hrdata_o;
      if (wr) mdl[idx] = (idx == ppb_pkg::IDX_PIO_CTRL) ?
         wd[7:0] & ppb_pkg::PIO_CTRL_MASK : wd[7:0];
   endtask : ahb
   task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
      ahb(1'b0, idx, 32'h0);
      check($sformatf("reg %h", idx), exp, rd);
      check("hresp", 32'h0, {31'h0, hresp_o});
   endtask : rd_chk
   task automatic pins(input string n, input ppb_pkg::ppb_pins_t p, input logic [7:0] oe, o);
      check({n, " oe"}, oe, p.oe);
      check({n, " out"}, o & oe, p.o & oe);
   endtask : pins
   // Pin outputs are registered one edge behind the register write.
   task automatic settle();
      repeat (3) @(posedge clk_i);
      #1;
   endtask : settle
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {hsel_i, hwrite_i, htrans_i, haddr_i, hwdata_i, oc_owns_pin3_i, oc_pin3_level_i} = '0;
      hsize_i = ppb_pkg::HSIZE_WORD;
      {bus_i, periph_i, ext} = '0;
      mdl = '{default: 8'h00};
      rst_i = 1'b1;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 5; i++) rd_chk(tbl[i], 32'h0);
      rd_chk(8'h3F, 32'h0);
      for (int k = 0; k < 4; k++) begin
         foreach (tbl[i]) ahb(1'b1, tbl[i], $random(seed));
         ahb(1'b1, ppb_pkg::IDX_PIO_CTRL, {26'h0, k[0], 5'h0});
         r = $random(seed);
         ext <= r[23:0];
         for (int i = 0; i < 5; i++) rd_chk(tbl[i], mdl[tbl[i]]);
         settle();
         pins("b", portb_o, mdl[ppb_pkg::IDX_PB_DIR], mdl[ppb_pkg::IDX_PB_VAL]);
         d = mdl[ppb_pkg::IDX_PC_DIR];
         v = mdl[ppb_pkg::IDX_PC_VAL];
         pins("c", port_c_value_o, k[0] ? d & ~v : d, k[0] ? 8'h00 : v);
         d = mdl[ppb_pkg::IDX_PD_DIR];
         v = mdl[ppb_pkg::IDX_PD_VAL];
         pins("d", port_d_value_o, d, v);
         p = (d & v) | (~d & ext[23:16]);
         rd_chk(ppb_pkg::IDX_PD_VAL, {24'h0, p});
         check("periph in", {p[5:2], p[0], 1'b0}, port_d_value_to_periph_o);
         v = mdl[ppb_pkg::IDX_PA_CTRL];
         check("pa ctrl", {v[7], v[3], v[2], 1'b0}, {porta_bit7_dir_o, porta_pin3_oe_o,
            capture_compare_select_o, porta_pin3_o});
      end
      ahb(1'b1, ppb_pkg::IDX_PIO_CTRL, 32'h0);
      for (int k = 0; k < 4; k++) begin
         periph_i <= {1'b1, k[1], 3'h7, 6'h0};
         ahb(1'b1, ppb_pkg::IDX_PD_DIR, $random(seed));
         settle();
         d = mdl[ppb_pkg::IDX_PD_DIR];
         check("spi oe", {k[1] & d[5], d[4:2]}, port_d_value_o.oe[5:2]);
      end
      // Expanded bus, peripherals and compare all toggle together for the checker.
      repeat (200) begin
         @(posedge clk_i);
         r = $random(seed);
         bus_i <= {1'b1, r[26:0]};
         periph_i <= r[10:0];
         {oc_owns_pin3_i, oc_pin3_level_i} <= r[29:28];
         ext <= r[31:8];
      end
      @(posedge clk_i);
      rst_i <= 1'b1;
      bus_i <= {4'b1100, 24'h0};
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
      check("c bus oe", 8'hFF, port_c_value_o.oe);
      rd_chk(ppb_pkg::IDX_PC_DIR, 32'h0);
      conclude();
   end
endmodule : testbench

// ### pkg/ppb_pkg.sv
// Overview of operation
// - Port B direction bit 0 makes pin input, 1 makes output; resets to zero.
// - Port C is general I/O single-chip; multiplexed address/data in expanded mode.
// - Port C direction bit 0 input, 1 output; register resets to zero.
// - After reset in expanded mode port C is the multiplexed address/data bus.
// - Port D reads anytime: inputs give pin level, outputs give driver input.
// - Port D writes go to a latch, driven only where pin is general output.
// - Port D direction bit 0 input, 1 output in general I/O; resets to zero.
// - Expanded and test modes force port D bits 6 and 7 to strobe and direction.
// - Enabled SPI makes port D bit 5 slave select; slave mode ignores its direction.
// - SPI master: bit-5 direction 0 gives error-detect input, 1 gives general output.
// - SPI input pins among bits 2 to 4 are inputs whatever direction holds.
// - SPI output pins among bits 2 to 4 drive only when direction bit set.
// - UART takes its port D pins whenever it claims them; SPI output pins also need their direction bit set.
// - Port A bit-3 direction 0 input, 1 output; output compare overrides it.
// - Capture/compare select 0 enables compare five, 1 capture four; resets to 0.
// - Port C open-drain bit 0 push-pull, 1 open-drain for all pins; reset clears.
// - Only the open-drain bit of the control register works; other bits read zero.
// - Expanded mode drives port B pins with the high address byte.
package ppb_pkg;

   localparam logic [7:0] IDX_PIO_CTRL = 8'h02;
   localparam logic [7:0] IDX_PB_VAL   = 8'h04;
   localparam logic [7:0] IDX_PB_DIR   = 8'h06;
   localparam logic [7:0] IDX_PD_VAL   = 8'h08;
   localparam logic [7:0] IDX_PD_DIR   = 8'h09;
   localparam logic [7:0] IDX_PC_VAL   = 8'h0A;
   localparam logic [7:0] IDX_PC_DIR   = 8'h0B;
   localparam logic [7:0] IDX_PA_CTRL  = 8'h26;
   localparam int         IDX_W      = 8;

   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam int         OPEN_DRAIN_BIT = 5;
   localparam int         PA_B7_DIR_BIT  = 7;
   localparam int         PA_B3_DIR_BIT  = 3;
   localparam int         CCSEL_BIT      = 2;
   localparam logic [7:0] PIO_CTRL_MASK  = 8'h20;
   localparam int         PD_SS     = 5;
   localparam int         PD_STROBE = 6;
   localparam int         PD_RW  = 7;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ    = 2'h3;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;

   typedef struct packed {
      logic       spi_en;
      logic       spi_master;
      logic [2:0] spi_drives;
      logic [2:0] spi_out;
      logic       uart_rx_en;
      logic       uart_tx_en;
      logic       uart_tx;
   } ppb_periph_t;

   typedef struct packed {
      logic       expanded;
      logic       addr_phase;
      logic       rd_nwr;
      logic       strobe;
      logic [15:0] addr;
      logic [7:0] wdata;
   } ppb_bus_t;

   typedef struct packed {
      logic [7:0] o;
      logic [7:0] oe;
   } ppb_pins_t;

endpackage : ppb_pkg

// ### rtl/ppb_top.sv
module ppb_top (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 hsel_i,
   input  wire logic [31:0]          haddr_i,
   input  wire logic [1:0]           htrans_i,
   input  wire logic                 hwrite_i,
   input  wire logic [2:0]           hsize_i,
   input  wire logic [31:0]          hwdata_i,
   input  wire logic                 hready_i,
   output logic      [31:0]          hrdata_o,
   output logic                      hreadyout_o,
   output logic                      hresp_o,
   input  wire ppb_pkg::ppb_bus_t    bus_i,
   input  wire ppb_pkg::ppb_periph_t periph_i,
   input  wire logic                 oc_owns_pin3_i,
   input  wire logic                 oc_pin3_level_i,
   input  wire logic [7:0]           portb_pins_i,
   input  wire logic [7:0]           port_c_value_pins_i,
   input  wire logic [7:0]           port_d_value_pins_i,
   output ppb_pkg::ppb_pins_t        portb_o,
   output ppb_pkg::ppb_pins_t        port_c_value_o,
   output ppb_pkg::ppb_pins_t        port_d_value_o,
   output logic [7:0]                port_c_value_data_o,
   output logic [5:0]                port_d_value_to_periph_o,
   output logic                      porta_pin3_o,
   output logic                      porta_pin3_oe_o,
   output logic                      porta_bit7_dir_o,
   output logic                      capture_compare_select_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Register state.
   logic [7:0] pio_ctrl_q;
   logic [7:0] portb_dir_bits_q;
   logic [7:0] portb_val_q;
   logic [7:0] port_c_value_dir_bits_q;
   logic [7:0] port_c_value_val_q;
   logic [7:0] port_d_value_dir_bits_q;
   logic [7:0] port_d_value_val_q;
   logic [7:0] pa_ctrl_q;
   logic       wr_pend_q;
   logic [7:0] wr_idx_q;

   // Bus decode.
   logic [7:0] wr_byte;
   logic [7:0] rd_idx;
   logic       hit_pio_ctrl;
   logic       hit_pb_dir;
   logic       hit_pb_val;
   logic       hit_pc_dir;
   logic       hit_pc_val;
   logic       hit_pd_dir;
   logic       hit_pd_val;
   logic       hit_pa_ctrl;

   logic       acc_ok;
   logic       wr_now;
   logic [7:0] rd_byte;
   logic [7:0] port_d_value_oe_d;
   logic [7:0] port_d_value_o_d;
   logic [7:0] port_c_value_oe_d;
   logic [7:0] port_c_value_o_d;
   logic [7:0] port_d_value_sense;

   function automatic logic [7:0] pin_view(input logic [7:0] oe, input logic [7:0] drv,
                                            input logic [7:0] pin);
      pin_view = (oe & drv) | (~oe & pin);
   endfunction : pin_view

   // True in the data phase of an accepted write to register index idx.
   function automatic logic reg_hit(input logic pend, input logic [7:0] at,
                                    input logic [7:0] idx);
      reg_hit = pend && (at == idx);
   endfunction : reg_hit

   // Register value as a read sees it while a write to that register is in flight.
   function automatic logic [7:0] fresh(input logic hit, input logic [7:0] q,
                                        input logic [7:0] wd);
      fresh = hit ? wd : q;
   endfunction : fresh

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave: zero wait states, always OKAY, unmapped reads give zero.
   assign acc_ok = hsel_i && hready_i && htrans_i[1];
   assign wr_now  = wr_pend_q;
   assign wr_byte = hwdata_i[7:0];
   assign rd_idx  = haddr_i[9:2];

   // Write strobes of the data phase, one per register.
   assign hit_pio_ctrl = reg_hit(wr_now, wr_idx_q, ppb_pkg::IDX_PIO_CTRL);
   assign hit_pb_dir   = reg_hit(wr_now, wr_idx_q, ppb_pkg::IDX_PB_DIR);
   assign hit_pb_val   = reg_hit(wr_now, wr_idx_q, ppb_pkg::IDX_PB_VAL);
   assign hit_pc_dir   = reg_hit(wr_now, wr_idx_q, ppb_pkg::IDX_PC_DIR);
   assign hit_pc_val   = reg_hit(wr_now, wr_idx_q, ppb_pkg::IDX_PC_VAL);
   assign hit_pd_dir   = reg_hit(wr_now, wr_idx_q, ppb_pkg::IDX_PD_DIR);
   assign hit_pd_val   = reg_hit(wr_now, wr_idx_q, ppb_pkg::IDX_PD_VAL);
   assign hit_pa_ctrl  = reg_hit(wr_now, wr_idx_q, ppb_pkg::IDX_PA_CTRL);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_pend_q <= 1'b0;
         wr_idx_q  <= ppb_pkg::RESET_BYTE;
      end else if (hready_i) begin
         wr_pend_q <= acc_ok && hwrite_i;
         wr_idx_q  <= haddr_i[9:2];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hreadyout_o <= 1'b0;
         hresp_o     <= 1'b0;
      end else begin
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end
   end

   // A read right behind a write to the same register must see that write, yet the
   // register only takes it at the end of the read's address phase, so it is passed on.
   // Port value reads show the pins and therefore lag a write by the pin register.
   always_comb begin
      unique case (rd_idx)
         ppb_pkg::IDX_PIO_CTRL: begin
            rd_byte = fresh(hit_pio_ctrl, pio_ctrl_q,
                            wr_byte & ppb_pkg::PIO_CTRL_MASK);
         end
         ppb_pkg::IDX_PB_VAL: begin
            rd_byte = pin_view(portb_o.oe, portb_o.o, portb_pins_i);
         end
         ppb_pkg::IDX_PB_DIR: begin
            rd_byte = fresh(hit_pb_dir, portb_dir_bits_q, wr_byte);
         end
         ppb_pkg::IDX_PD_VAL: begin
            rd_byte = port_d_value_sense;
         end
         ppb_pkg::IDX_PD_DIR: begin
            rd_byte = fresh(hit_pd_dir, port_d_value_dir_bits_q, wr_byte);
         end
         ppb_pkg::IDX_PC_VAL: begin
            rd_byte = pin_view(port_c_value_o.oe, port_c_value_o.o, port_c_value_pins_i);
         end
         ppb_pkg::IDX_PC_DIR: begin
            rd_byte = fresh(hit_pc_dir, port_c_value_dir_bits_q, wr_byte);
         end
         ppb_pkg::IDX_PA_CTRL: begin
            rd_byte = fresh(hit_pa_ctrl, pa_ctrl_q, wr_byte);
         end
         default: begin
            rd_byte = ppb_pkg::RESET_BYTE;
         end
      endcase
   end

   // Read data is registered in the address phase so it stands in the data phase.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hrdata_o <= 32'h0000_0000;
      end else if (acc_ok && !hwrite_i) begin
         hrdata_o <= {24'h00_0000, rd_byte};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes, taken in the data phase.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pio_ctrl_q <= ppb_pkg::RESET_BYTE;
      end else if (hit_pio_ctrl) begin
         pio_ctrl_q <= wr_byte & ppb_pkg::PIO_CTRL_MASK;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         portb_dir_bits_q <= ppb_pkg::RESET_BYTE;
         portb_val_q      <= ppb_pkg::RESET_BYTE;
      end else if (wr_now) begin
         if (hit_pb_dir) begin
            portb_dir_bits_q <= hwdata_i[7:0];
         end
         if (hit_pb_val) begin
            portb_val_q <= hwdata_i[7:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_c_value_dir_bits_q <= ppb_pkg::RESET_BYTE;
         port_c_value_val_q      <= ppb_pkg::RESET_BYTE;
      end else if (wr_now) begin
         if (hit_pc_dir) begin
            port_c_value_dir_bits_q <= hwdata_i[7:0];
         end
         if (hit_pc_val) begin
            port_c_value_val_q <= hwdata_i[7:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_d_value_dir_bits_q <= ppb_pkg::RESET_BYTE;
         port_d_value_val_q      <= ppb_pkg::RESET_BYTE;
      end else if (wr_now) begin
         if (hit_pd_dir) begin
            port_d_value_dir_bits_q <= hwdata_i[7:0];
         end
         if (hit_pd_val) begin
            port_d_value_val_q <= hwdata_i[7:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pa_ctrl_q <= ppb_pkg::RESET_BYTE;
      end else if (hit_pa_ctrl) begin
         pa_ctrl_q <= wr_byte;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Port D pin ownership.
   always_comb begin
      port_d_value_oe_d = port_d_value_dir_bits_q;
      port_d_value_o_d  = port_d_value_val_q;
      if (periph_i.uart_rx_en) begin
         port_d_value_oe_d[0] = 1'b0;
      end
      if (periph_i.uart_tx_en) begin
         port_d_value_oe_d[1] = 1'b1;
         port_d_value_o_d[1]  = periph_i.uart_tx;
      end
      if (periph_i.spi_en) begin
         for (int i = 0; i < 3; i++) begin
            if (periph_i.spi_drives[i]) begin
               port_d_value_oe_d[2+i] = port_d_value_dir_bits_q[2+i];
               port_d_value_o_d[2+i]  = periph_i.spi_out[i];
            end else begin
               port_d_value_oe_d[2+i] = 1'b0;
            end
         end
         if (!periph_i.spi_master) begin
            port_d_value_oe_d[ppb_pkg::PD_SS] = 1'b0;
         end else begin
            // A clear direction bit leaves the pin as the error-detect input.
            port_d_value_oe_d[ppb_pkg::PD_SS] = port_d_value_dir_bits_q[ppb_pkg::PD_SS];
         end
      end
      if (bus_i.expanded) begin
         port_d_value_oe_d[ppb_pkg::PD_STROBE] = 1'b1;
         port_d_value_o_d[ppb_pkg::PD_STROBE]  = bus_i.strobe;
         port_d_value_oe_d[ppb_pkg::PD_RW] = 1'b1;
         port_d_value_o_d[ppb_pkg::PD_RW]  = bus_i.rd_nwr;
      end
   end

   // Output pins report the driver input, i.e. what this block drives.
   assign port_d_value_sense = pin_view(port_d_value_o.oe, port_d_value_o.o, port_d_value_pins_i);

   ////////////////////////////////////////////////////////////////////////////
   // Port C: general I/O or multiplexed low address/data.
   always_comb begin
      if (bus_i.expanded) begin
         port_c_value_o_d  = bus_i.addr_phase ? bus_i.addr[7:0] : bus_i.wdata;
         port_c_value_oe_d = {8{bus_i.addr_phase || !bus_i.rd_nwr}};
      end else begin
         port_c_value_o_d  = port_c_value_val_q;
         port_c_value_oe_d = port_c_value_dir_bits_q;
      end
      if (pio_ctrl_q[ppb_pkg::OPEN_DRAIN_BIT]) begin
         port_c_value_oe_d = port_c_value_oe_d & ~port_c_value_o_d;
         port_c_value_o_d  = ppb_pkg::RESET_BYTE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered pin outputs.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         portb_o <= '0;
      end else if (bus_i.expanded) begin
         portb_o.o  <= bus_i.addr[15:8];
         portb_o.oe <= 8'hFF;
      end else begin
         portb_o.o  <= portb_val_q;
         portb_o.oe <= portb_dir_bits_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_c_value_o <= '0;
      end else begin
         port_c_value_o.o  <= port_c_value_o_d;
         port_c_value_o.oe <= port_c_value_oe_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_d_value_o <= '0;
      end else begin
         port_d_value_o.o  <= port_d_value_o_d;
         port_d_value_o.oe <= port_d_value_oe_d;
      end
   end

   // Bus read data is taken from the pins whatever the mode; the core qualifies it.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_c_value_data_o <= ppb_pkg::RESET_BYTE;
      end else begin
         port_c_value_data_o <= port_c_value_pins_i;
      end
   end

   // Peripheral inputs: RxD, MISO, MOSI, SCK, slave select/error detect.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_d_value_to_periph_o <= 6'h00;
      end else begin
         port_d_value_to_periph_o <= {port_d_value_pins_i[5:2], port_d_value_pins_i[0], 1'b0};
      end
   end

   // Port A pin 3: output compare wins over the direction bit.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         porta_pin3_o    <= 1'b0;
         porta_pin3_oe_o <= 1'b0;
      end else begin
         porta_pin3_oe_o <= oc_owns_pin3_i || pa_ctrl_q[ppb_pkg::PA_B3_DIR_BIT];
         porta_pin3_o    <= oc_owns_pin3_i ? oc_pin3_level_i : 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         porta_bit7_dir_o         <= 1'b0;
         capture_compare_select_o <= 1'b0;
      end else begin
         porta_bit7_dir_o         <= pa_ctrl_q[ppb_pkg::PA_B7_DIR_BIT];
         capture_compare_select_o <= pa_ctrl_q[ppb_pkg::CCSEL_BIT];
      end
   end

endmodule : ppb_top
